// >>> hdl/bp_pkg.sv
// Constants, field layouts and carrier types for the breakpoint channel block
package bp_pkg;
  // ****************************************************************
  // Register selectors and reset values
  // ****************************************************************
  localparam logic [1:0]  SEL_CTRL_LOW   = 2'h0;
  localparam logic [1:0]  SEL_CTRL_HIGH  = 2'h1;
  localparam logic [1:0]  SEL_STATUS     = 2'h2;
  localparam logic [1:0]  SEL_BANK       = 2'h3;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] STATUS_RESET   = 16'h0000;
  localparam logic [23:0] CAR_RESET      = 24'h000000;
  localparam logic [1:0]  ISE_DISP_RESET = 2'h2;
  localparam logic [15:0] HIGH_WR_MASK   = 16'h00BD;
  localparam logic [15:0] ALT_BITS_MASK  = 16'h003C;
  localparam logic [15:0] STATUS_MASK    = 16'h007F;
  localparam int          BANKS          = 4;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int F_MASK0 = 0;
  localparam int F_EAR   = 2;
  localparam int F_WPE0  = 3;
  localparam int F_PC0   = 4;
  localparam int F_CWR0  = 5;
  localparam int F_CRD0  = 6;
  localparam int F_DEN0  = 7;
  localparam int F_MASK1 = 8;
  localparam int F_ESQ   = 10;
  localparam int CH_STEP = 8;
  localparam int H_EFB   = 0;
  localparam int H_ALT_BREAKPOINT_DISPATCH  = 2;
  localparam int H_ALT_TRACE_DISPATCH  = 3;
  localparam int H_ALT_DEBUG_TRAP_DISPATCH  = 4;
  localparam int H_ALT_EMULATOR_DISPATCH  = 5;
  localparam int H_LOCK  = 7;
  localparam int S_PC0   = 0;
  localparam int S_WR0   = 1;
  localparam int S_RD0   = 2;
  localparam int S_TAG   = 3;
  localparam int S_PC1   = 4;
  localparam int S_WR1   = 5;
  localparam int S_RD1   = 6;

  typedef struct packed {
    logic        pc_valid;
    logic [23:0] pc;
    logic        rd_valid;
    logic        wr_valid;
    logic [23:0] data_addr;
    logic        tagged_exec;
  } core_event_t;

  typedef struct packed {
    logic        ack_cycle;
    logic        base_zero;
  } dispatch_t;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_ARMED = 2'b01
  } seq_state_t;
endpackage : bp_pkg

// >>> hdl/bp_compare.sv
// Masked compare of one address against one channel
`timescale 1ns/1ns
module bp_compare (
  input  wire logic [23:0] addr,
  input  wire logic [23:0] lower,
  input  wire logic [23:0] upper,
  input  wire logic [1:0]  mask_sel,
  input  wire logic        range_on,
  output logic             hit
);
  logic [23:0] keep;
  logic [23:0] a_m;
  logic [23:0] l_m;
  logic [23:0] u_m;
  always_comb begin
    case (mask_sel)
      2'h0:    keep = 24'hFFFFFF;
      2'h1:    keep = 24'hFFFFFE;
      2'h2:    keep = 24'hFFFFFC;
      default: keep = 24'hFFFFF8;
    endcase
    a_m = addr & keep;
    l_m = lower & keep;
    u_m = upper & keep;
    if (range_on) begin
      hit = (a_m >= l_m) && (a_m <= u_m);
    end else begin
      hit = (a_m == l_m);
    end
  end
endmodule : bp_compare

// >>> hdl/bp_channel_ctrl.sv
// Breakpoint control and status for four banks of two debug channels
`timescale 1ns/1ns
module bp_channel_ctrl (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                debug_reset_in,
  input  wire logic                hw_debug_mode,
  input  wire logic                reg_wr,
  input  wire logic [1:0]          reg_sel,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                car_wr,
  input  wire logic                car_sel,
  input  wire logic [23:0]         car_wdata,
  input  wire bp_pkg::core_event_t core_evt,
  input  wire logic                chip_debug_on_in,
  output logic [15:0]              reg_rdata,
  output logic [1:0]               debug_trap,
  output logic [7:0]               watch_event_out,
  output logic [7:0]               channel_event_summary,
  output bp_pkg::dispatch_t        bpt_disp,
  output bp_pkg::dispatch_t        trc_disp,
  output bp_pkg::dispatch_t        dbg_disp,
  output bp_pkg::dispatch_t        ise_disp,
  output logic                     chip_debug_on
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [15:0] ctrl_lo     [bp_pkg::BANKS];
  logic [15:0] stat        [bp_pkg::BANKS];
  logic [23:0] cmp_addr    [2*bp_pkg::BANKS];
  logic [15:0] ctrl_hi;
  logic [1:0]  bank;
  bp_pkg::seq_state_t seq  [bp_pkg::BANKS];
  logic [15:0] next_ctrl_lo [bp_pkg::BANKS];
  logic [15:0] next_stat    [bp_pkg::BANKS];
  logic [23:0] next_cmp_addr[2*bp_pkg::BANKS];
  logic [15:0] next_ctrl_hi;
  logic [1:0]  next_bank;
  bp_pkg::seq_state_t next_seq [bp_pkg::BANKS];
  logic [15:0] next_rdata;
  logic [1:0]  next_trap;
  logic [7:0]  next_watch;
  logic [7:0]  next_summary;
  logic        next_chip_on;
  logic        any_set [bp_pkg::BANKS];
  logic        tag_set;
  logic        core_acc;

  // Channel bits of one control word for channel c
  function automatic logic chbit(input logic [15:0] w, input int f, input int c);
    chbit = w[f + c*bp_pkg::CH_STEP];
  endfunction : chbit

  assign core_acc = reg_wr && !hw_debug_mode;

  // ****************************************************************
  // Comparators
  // ****************************************************************
  logic pc_cmp [2*bp_pkg::BANKS];
  logic da_cmp [2*bp_pkg::BANKS];
  genvar g;
  generate
    for (g = 0; g < 2*bp_pkg::BANKS; g++) begin : g_cmp
      localparam int B = g / 2;
      localparam int C = g % 2;
      logic rng;
      // Range compare lives only on the lower channel of a pair
      assign rng = (C == 0) && ctrl_lo[B][bp_pkg::F_EAR] && !ctrl_lo[B][bp_pkg::F_ESQ];
      bp_compare u_pc (
        .addr     (core_evt.pc),
        .lower    (cmp_addr[g]),
        .upper    (cmp_addr[(C == 0) ? g + 1 : g]),
        .mask_sel (ctrl_lo[B][bp_pkg::F_MASK0 + C*bp_pkg::CH_STEP +: 2]),
        .range_on (rng),
        .hit      (pc_cmp[g])
      );
      bp_compare u_da (
        .addr     (core_evt.data_addr),
        .lower    (cmp_addr[g]),
        .upper    (cmp_addr[(C == 0) ? g + 1 : g]),
        .mask_sel (ctrl_lo[B][bp_pkg::F_MASK0 + C*bp_pkg::CH_STEP +: 2]),
        .range_on (rng),
        .hit      (da_cmp[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [2:0] cond [2];
    logic       rng_mode;
    logic       seq_mode;
    logic       l_cond;
    logic       u_cond;
    logic [15:0] clr;
    for (int i = 0; i < 2; i++) begin
      cond[i] = 3'h0;
    end
    rng_mode = 1'b0;
    seq_mode = 1'b0;
    l_cond = 1'b0;
    u_cond = 1'b0;
    clr = 16'h0000;
    next_ctrl_hi = ctrl_hi;
    next_bank    = bank;
    next_trap    = 2'h0;
    next_watch   = 8'h00;
    tag_set      = core_evt.tagged_exec && ctrl_hi[bp_pkg::H_EFB];
    for (int a = 0; a < 2*bp_pkg::BANKS; a++) begin
      next_cmp_addr[a] = cmp_addr[a];
    end
    for (int b = 0; b < bp_pkg::BANKS; b++) begin
      next_ctrl_lo[b] = ctrl_lo[b];
      next_stat[b]    = stat[b];
      next_seq[b]     = seq[b];
      rng_mode = ctrl_lo[b][bp_pkg::F_EAR] && !ctrl_lo[b][bp_pkg::F_ESQ];
      seq_mode = ctrl_lo[b][bp_pkg::F_ESQ];
      for (int c = 0; c < 2; c++) begin
        // Bits: 0 PC, 1 write, 2 read; range mode uses channel 0 config
        int cc;
        cc = rng_mode ? 0 : c;
        cond[c][0] = chbit(ctrl_lo[b], bp_pkg::F_PC0, cc) && core_evt.pc_valid
                     && pc_cmp[2*b+c];
        cond[c][1] = !chbit(ctrl_lo[b], bp_pkg::F_PC0, cc) && core_evt.wr_valid
                     && chbit(ctrl_lo[b], bp_pkg::F_CWR0, cc) && da_cmp[2*b+c];
        cond[c][2] = !chbit(ctrl_lo[b], bp_pkg::F_PC0, cc) && core_evt.rd_valid
                     && chbit(ctrl_lo[b], bp_pkg::F_CRD0, cc) && da_cmp[2*b+c];
        cond[c] = cond[c] & {3{chbit(ctrl_lo[b], bp_pkg::F_DEN0, cc)}};
      end
      if (rng_mode) begin
        cond[1] = 3'h0;
      end
      l_cond = |cond[0];
      u_cond = |cond[1];
      if (seq_mode) begin
        // The lower condition only arms; the upper one fires once armed
        next_seq[b] = (seq[b] == bp_pkg::SEQ_ARMED || l_cond) ? bp_pkg::SEQ_ARMED
                      : bp_pkg::SEQ_IDLE;
        if (seq[b] != bp_pkg::SEQ_ARMED) begin
          cond[1] = 3'h0;
        end
        cond[0] = 3'h0;
      end else begin
        next_seq[b] = bp_pkg::SEQ_IDLE;
      end
      // Every condition that survives the range and sequence gating lands in status together
      next_stat[b][bp_pkg::S_PC0] = stat[b][bp_pkg::S_PC0] | cond[0][0];
      next_stat[b][bp_pkg::S_WR0] = stat[b][bp_pkg::S_WR0] | cond[0][1];
      next_stat[b][bp_pkg::S_RD0] = stat[b][bp_pkg::S_RD0] | cond[0][2];
      next_stat[b][bp_pkg::S_PC1] = stat[b][bp_pkg::S_PC1] | cond[1][0];
      next_stat[b][bp_pkg::S_WR1] = stat[b][bp_pkg::S_WR1] | cond[1][1];
      next_stat[b][bp_pkg::S_RD1] = stat[b][bp_pkg::S_RD1] | cond[1][2];
      any_set[b] = l_cond && !seq_mode || (|cond[1]);
      if (seq_mode && (|cond[1])) begin
        next_seq[b] = bp_pkg::SEQ_IDLE;
      end
      next_trap[0] = next_trap[0] | any_set[b];
      if (hw_debug_mode) begin
        for (int c = 0; c < 2; c++) begin
          next_watch[2*b+c] = chbit(ctrl_lo[b], bp_pkg::F_WPE0, c)
                              && (|cond[c]);
        end
      end
      // Software write first, so the hardware enable clear and tag set override it; other status sets survive only on bits that were clear
      if (core_acc && bank == b[1:0]) begin
        if (reg_sel == bp_pkg::SEL_CTRL_LOW) begin
          next_ctrl_lo[b] = reg_wdata;
          next_seq[b] = bp_pkg::SEQ_IDLE;
        end
        if (reg_sel == bp_pkg::SEL_STATUS) begin
          next_stat[b] = (stat[b] & reg_wdata) | (next_stat[b] & ~stat[b]);
        end
      end
      if (b == 0) begin
        next_stat[b][bp_pkg::S_TAG] = next_stat[b][bp_pkg::S_TAG] | tag_set;
      end else begin
        next_stat[b][bp_pkg::S_TAG] = 1'b0;
      end
      next_stat[b] = next_stat[b] & bp_pkg::STATUS_MASK;
    end
    next_trap[1] = tag_set;
    // Clear a block's condition enables on a hit in that block, and EFB on a hit in any block
    for (int b = 0; b < bp_pkg::BANKS; b++) begin
      if (any_set[b] || (b == 0 && tag_set)) begin
        next_ctrl_lo[b][bp_pkg::F_DEN0] = 1'b0;
        next_ctrl_lo[b][bp_pkg::F_DEN0 + bp_pkg::CH_STEP] = 1'b0;
        clr[bp_pkg::H_EFB] = 1'b1;
      end
    end
    if (core_acc && bank == 2'h0 && reg_sel == bp_pkg::SEL_CTRL_HIGH) begin
      next_ctrl_hi = reg_wdata & bp_pkg::HIGH_WR_MASK;
      if (ctrl_hi[bp_pkg::H_LOCK]) begin
        next_ctrl_hi = next_ctrl_hi | (ctrl_hi & bp_pkg::ALT_BITS_MASK);
        next_ctrl_hi[bp_pkg::H_LOCK] = 1'b1;
      end
    end
    next_ctrl_hi[bp_pkg::H_EFB] = next_ctrl_hi[bp_pkg::H_EFB] & !clr[bp_pkg::H_EFB];
    if (core_acc && reg_sel == bp_pkg::SEL_BANK) begin
      next_bank = reg_wdata[1:0];
    end
    if (car_wr && !hw_debug_mode) begin
      next_cmp_addr[{bank, car_sel}] = car_wdata;
    end
    // Lock holds the chip debug-on flag against clearing
    next_chip_on = chip_debug_on_in | (ctrl_hi[bp_pkg::H_LOCK] & chip_debug_on);
    for (int k = 0; k < 2*bp_pkg::BANKS; k++) begin
      next_summary[k] = next_stat[k/2][(k%2 == 0) ? bp_pkg::S_PC0 : bp_pkg::S_PC1]
                      | next_stat[k/2][(k%2 == 0) ? bp_pkg::S_WR0 : bp_pkg::S_WR1]
                      | next_stat[k/2][(k%2 == 0) ? bp_pkg::S_RD0 : bp_pkg::S_RD1]
                      | ((k == 0) ? next_stat[0][bp_pkg::S_TAG] : 1'b0);
    end
    case (reg_sel)
      bp_pkg::SEL_CTRL_LOW:  next_rdata = ctrl_lo[bank];
      bp_pkg::SEL_CTRL_HIGH: next_rdata = (bank == 2'h0) ? ctrl_hi : 16'h0000;
      bp_pkg::SEL_STATUS:    next_rdata = stat[bank];
      default:               next_rdata = {channel_event_summary, 6'h00, bank};
    endcase
    if (hw_debug_mode) begin
      next_rdata = 16'h0000;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst || debug_reset_in) begin
      for (int b = 0; b < bp_pkg::BANKS; b++) begin
        ctrl_lo[b] <= bp_pkg::CTRL_RESET;
        stat[b]    <= bp_pkg::STATUS_RESET;
        seq[b]     <= bp_pkg::SEQ_IDLE;
      end
      for (int a = 0; a < 2*bp_pkg::BANKS; a++) begin
        cmp_addr[a] <= bp_pkg::CAR_RESET;
      end
      ctrl_hi               <= bp_pkg::CTRL_RESET;
      bank                  <= 2'h0;
      reg_rdata             <= 16'h0000;
      debug_trap            <= 2'h0;
      watch_event_out       <= 8'h00;
      channel_event_summary <= 8'h00;
      bpt_disp              <= '0;
      trc_disp              <= '0;
      dbg_disp              <= '0;
      ise_disp              <= bp_pkg::ISE_DISP_RESET;
      chip_debug_on         <= 1'b0;
    end else begin
      ctrl_lo               <= next_ctrl_lo;
      stat                  <= next_stat;
      seq                   <= next_seq;
      cmp_addr              <= next_cmp_addr;
      ctrl_hi               <= next_ctrl_hi;
      bank                  <= next_bank;
      reg_rdata             <= next_rdata;
      debug_trap            <= next_trap;
      watch_event_out       <= next_watch;
      channel_event_summary <= next_summary;
      bpt_disp <= {2{next_ctrl_hi[bp_pkg::H_ALT_BREAKPOINT_DISPATCH]}};
      trc_disp <= {2{next_ctrl_hi[bp_pkg::H_ALT_TRACE_DISPATCH]}};
      dbg_disp <= {2{next_ctrl_hi[bp_pkg::H_ALT_DEBUG_TRAP_DISPATCH]}};
      ise_disp <= {1'b1, next_ctrl_hi[bp_pkg::H_ALT_EMULATOR_DISPATCH]};
      chip_debug_on <= next_chip_on;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_tag_taken;
    core_evt.tagged_exec && ctrl_hi[bp_pkg::H_EFB] && !debug_reset_in;
  endsequence
  property p_tag_status;
    @(posedge clk) disable iff (rst || debug_reset_in)
      s_tag_taken |=> stat[0][bp_pkg::S_TAG] && !ctrl_hi[bp_pkg::H_EFB]
                     && debug_trap[1] && channel_event_summary[0];
  endproperty
  a_tag_status: assert property (p_tag_status) else $error("tag status not set");
  property p_den_clear;
    @(posedge clk) disable iff (rst || debug_reset_in)
      any_set[0] |=> !ctrl_lo[0][bp_pkg::F_DEN0] && !ctrl_lo[0][bp_pkg::F_DEN0+8];
  endproperty
  a_den_clear: assert property (p_den_clear) else $error("enables not cleared");
  property p_lock_hold;
    @(posedge clk) disable iff (rst || debug_reset_in)
      ctrl_hi[bp_pkg::H_LOCK] |=> ctrl_hi[bp_pkg::H_LOCK]
                                  && ((ctrl_hi & $past(ctrl_hi)) & bp_pkg::ALT_BITS_MASK)
                                     == ($past(ctrl_hi) & bp_pkg::ALT_BITS_MASK);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked bits changed");
  property p_range_upper_quiet;
    @(posedge clk) disable iff (rst || debug_reset_in)
      ctrl_lo[0][bp_pkg::F_EAR] && !ctrl_lo[0][bp_pkg::F_ESQ] && !core_acc
        |=> $stable(stat[0][6:4]);
  endproperty
  a_range_upper_quiet: assert property (p_range_upper_quiet) else $error("upper hit");
  property p_hidden;
    @(posedge clk) disable iff (rst || debug_reset_in)
      hw_debug_mode |=> reg_rdata == 16'h0000;
  endproperty
  a_hidden: assert property (p_hidden) else $error("register visible in debug mode");
  property p_status_sticky;
    @(posedge clk) disable iff (rst || debug_reset_in)
      stat[0][bp_pkg::S_PC0] && !(core_acc && reg_sel == bp_pkg::SEL_STATUS)
        |=> stat[0][bp_pkg::S_PC0];
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("status lost");
  property p_ise_ack;
    @(posedge clk) disable iff (rst || debug_reset_in)
      ##1 ise_disp.ack_cycle;
  endproperty
  a_ise_ack: assert property (p_ise_ack) else $error("emulator ack missing");
  property p_alt_bpt;
    @(posedge clk) disable iff (rst || debug_reset_in)
      ctrl_hi[bp_pkg::H_ALT_BREAKPOINT_DISPATCH] |-> bpt_disp.ack_cycle && bpt_disp.base_zero;
  endproperty
  a_alt_bpt: assert property (p_alt_bpt) else $error("alt dispatch wrong");
  property p_watch_gate;
    @(posedge clk) disable iff (rst || debug_reset_in)
      !hw_debug_mode |=> watch_event_out == 8'h00;
  endproperty
  a_watch_gate: assert property (p_watch_gate) else $error("watch out of debug mode");
  sequence s_seq_waiting;
    ctrl_lo[0][bp_pkg::F_ESQ] && seq[0] == bp_pkg::SEQ_IDLE && !core_acc;
  endsequence
  property p_seq_wait;
    @(posedge clk) disable iff (rst || debug_reset_in)
      s_seq_waiting |=> $stable(stat[0][6:4]);
  endproperty
  a_seq_wait: assert property (p_seq_wait) else $error("upper fired unarmed");
  property p_summary_or;
    @(posedge clk) disable iff (rst || debug_reset_in)
      channel_event_summary[1] == (|stat[0][6:4]);
  endproperty
  a_summary_or: assert property (p_summary_or) else $error("event summary wrong");
  property p_chip_on_lock;
    @(posedge clk) disable iff (rst || debug_reset_in)
      ctrl_hi[bp_pkg::H_LOCK] && chip_debug_on |=> chip_debug_on;
  endproperty
  a_chip_on_lock: assert property (p_chip_on_lock) else $error("debug-on lost");
  property p_dbg_reset;
    @(posedge clk) debug_reset_in |=> ctrl_hi == bp_pkg::CTRL_RESET
                                      && ctrl_lo[0] == bp_pkg::CTRL_RESET;
  endproperty
  a_dbg_reset: assert property (p_dbg_reset) else $error("control not cleared");
endmodule : bp_channel_ctrl

// >>> bench/bp_partner.sv
// Pipeline model that issues one core event per request from the bench
`timescale 1ns/1ns
module bp_partner (
  input  wire logic           clk,
  input  wire logic           go,
  input  wire logic [1:0]     kind,
  input  wire logic [23:0]    addr,
  output bp_pkg::core_event_t core_evt
);
  logic [23:0] last_addr = 24'hFFFFFF;
  // ****************************************************************
  // Event drive
  // ****************************************************************
  always @(posedge clk) begin
    if (go) begin
      last_addr <= addr;
    end
  end
  // Idle address lines show the inverse of the last value, so a stale match cannot pass
  always_comb begin
    core_evt             = '0;
    core_evt.pc          = go ? addr : ~last_addr;
    core_evt.data_addr   = go ? addr : ~last_addr;
    core_evt.pc_valid    = go && (kind == 2'h0);
    core_evt.rd_valid    = go && (kind == 2'h1);
    core_evt.wr_valid    = go && (kind == 2'h2);
    core_evt.tagged_exec = go && (kind == 2'h3);
  end
endmodule : bp_partner

// >>> bench/breakpoint_channel_control_bench.sv
// Self-checking bench for the breakpoint channel control block
`timescale 1ns/1ns
module breakpoint_channel_control_bench;
  logic clk = 1'b0, rst = 1'b1, debug_reset_in = 1'b0, hw_debug_mode = 1'b0;
  logic reg_wr = 1'b0, car_wr = 1'b0, car_sel = 1'b0, chip_debug_on_in = 1'b0, go = 1'b0;
  logic [1:0] reg_sel = 2'h0, kind = 2'h0, debug_trap;
  logic [15:0] reg_wdata = 16'h0000, v, reg_rdata;
  logic [23:0] car_wdata = 24'h000000, ev_addr = 24'h000000, a, b;
  logic [7:0] watch_event_out, channel_event_summary;
  bp_pkg::core_event_t core_evt;
  bp_pkg::dispatch_t bpt_disp, trc_disp, dbg_disp, ise_disp;
  logic chip_debug_on;
  int n_mismatch = 0, comparisons = 0, m;

  bp_partner bp_partner_i (.clk(clk), .go(go), .kind(kind), .addr(ev_addr), .core_evt(core_evt));
  bp_channel_ctrl bp_channel_ctrl_i (.clk(clk), .rst(rst), .debug_reset_in(debug_reset_in),
    .hw_debug_mode(hw_debug_mode), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
    .car_wr(car_wr), .car_sel(car_sel), .car_wdata(car_wdata), .core_evt(core_evt),
    .chip_debug_on_in(chip_debug_on_in), .reg_rdata(reg_rdata), .debug_trap(debug_trap),
    .watch_event_out(watch_event_out), .channel_event_summary(channel_event_summary),
    .bpt_disp(bpt_disp), .trc_disp(trc_disp), .dbg_disp(dbg_disp), .ise_disp(ise_disp),
    .chip_debug_on(chip_debug_on));

  initial begin
    forever #4 clk = ~clk;
  end
  // ****************************************************************
  // Expectations and bus tasks
  // ****************************************************************
  function automatic logic exp_hit(input logic [23:0] x, input logic [23:0] c, input int mk);
    return ((x ^ c) & ~((24'h000001 << mk) - 24'h000001)) == 24'h000000;
  endfunction : exp_hit
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] s, input logic [15:0] d);
    @(posedge clk);
    #1 {reg_wr, reg_sel, reg_wdata} = {1'b1, s, d};
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] s);
    @(posedge clk);
    #1 reg_sel = s;
    @(posedge clk);
    #1 v = reg_rdata;
  endtask : rd
  task automatic cw(input logic s, input logic [23:0] d);
    @(posedge clk);
    #1 {car_wr, car_sel, car_wdata} = {1'b1, s, d};
    @(posedge clk);
    #1 car_wr = 1'b0;
  endtask : cw
  // Leaves the bench 1 ns after the edge that samples the event, where trap pulses are visible
  task automatic ev(input logic [1:0] k, input logic [23:0] x);
    @(posedge clk);
    #1 {go, kind, ev_addr} = {1'b1, k, x};
    @(posedge clk);
    #1 go = 1'b0;
  endtask : ev
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  // Bounded run: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop;
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    void'($urandom(32'h3514c9b2));
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    for (int s = 0; s < 3; s++) begin
      rd(s[1:0]);
      chk(v, 16'h0000);
    end
    chk(ise_disp, 2'b10);
    chk(bpt_disp, 2'b00);
    a = 24'($urandom);
    wr(2'h1, 16'h0001);
    wr(2'h0, 16'h0090);
    cw(1'b0, a);
    ev(2'h0, a);
    chk(debug_trap, 2'b01);
    chk(channel_event_summary[0], 1'b1);
    rd(2'h0);
    chk(v, 16'h0010);
    rd(2'h1);
    chk(v, 16'h0000);
    rd(2'h2);
    chk(v, 16'h0001);
    wr(2'h2, 16'h0000);
    // Corners: one bit beyond the mask, then one bit inside it
    for (int i = 0; i < 16; i++) begin
      m = (i < 8) ? i % 4 : $urandom % 4;
      a = 24'($urandom);
      b = (i < 4) ? a ^ (24'h000001 << m) : (i < 8) ? a ^ ((24'h000001 << m) >> 1) :
          a ^ 24'($urandom % 16);
      wr(2'h0, 16'h0090 | 16'(m));
      cw(1'b0, a);
      ev(2'h0, b);
      chk(debug_trap[0], exp_hit(b, a, m));
      wr(2'h2, 16'h0000);
    end
    for (int i = 0; i < 6; i++) begin
      a = 24'($urandom) | 24'h000001;
      v = 16'h0080 | ((i > 1) ? (i[0] ? 16'h0020 : 16'h0040) : 16'h0000) |
          ((i > 3) ? 16'h0010 : 16'h0000);
      wr(2'h0, v);
      cw(1'b0, a);
      ev(i[0] ? 2'h2 : 2'h1, a);
      chk(debug_trap[0], i == 2 || i == 3);
      rd(2'h2);
      chk(v, (i == 3) ? 16'h0002 : (i == 2) ? 16'h0004 : 16'h0000);
      wr(2'h2, 16'h0000);
    end
    wr(2'h0, 16'h0010);
    ev(2'h0, a);
    chk(debug_trap, 2'b00);
    a = 24'($urandom % 32'h007FFF00);
    b = a + 24'h000040;
    cw(1'b1, b);
    for (int i = 0; i < 2; i++) begin
      wr(2'h0, 16'h0094);
      cw(1'b0, a);
      ev(2'h0, b + 24'(i));
      chk(debug_trap[0], i == 0);
      rd(2'h2);
      chk(v, (i == 0) ? 16'h0001 : 16'h0000);
      wr(2'h2, 16'h0000);
    end
    wr(2'h0, 16'h9490);
    ev(2'h0, b);
    chk(debug_trap[0], 1'b0);
    ev(2'h0, a);
    ev(2'h0, b);
    chk(debug_trap[0], 1'b1);
    rd(2'h2);
    chk(v & 16'h0010, 16'h0010);
    wr(2'h2, 16'h0000);
    wr(2'h0, 16'h0000);
    wr(2'h1, 16'h0001);
    ev(2'h3, a);
    chk(debug_trap, 2'b10);
    rd(2'h1);
    chk(v, 16'h0000);
    rd(2'h2);
    chk(v, 16'h0008);
    chk(channel_event_summary[0], 1'b1);
    wr(2'h2, 16'h0000);
    wr(2'h3, 16'h0001);
    rd(2'h3);
    chk(v[1:0], 2'h1);
    rd(2'h0);
    chk(v, 16'h0000);
    wr(2'h0, 16'h0A05);
    wr(2'h3, 16'h0000);
    rd(2'h0);
    chk(v, 16'h0000);
    wr(2'h3, 16'h0001);
    rd(2'h0);
    chk(v, 16'h0A05);
    wr(2'h0, 16'h0000);
    wr(2'h3, 16'h0000);
    chip_debug_on_in = 1'b1;
    wr(2'h1, 16'h00BC);
    rd(2'h1);
    chk({bpt_disp, trc_disp, dbg_disp, ise_disp, chip_debug_on}, 9'h1FF);
    chip_debug_on_in = 1'b0;
    wr(2'h1, 16'h0000);
    rd(2'h1);
    chk({v, chip_debug_on}, {16'h00BC, 1'b1});
    wr(2'h0, 16'h0098);
    cw(1'b0, a);
    hw_debug_mode = 1'b1;
    rd(2'h0);
    chk(v, 16'h0000);
    wr(2'h0, 16'h0000);
    ev(2'h0, a);
    chk(watch_event_out[0], 1'b1);
    hw_debug_mode = 1'b0;
    rd(2'h0);
    chk(v, 16'h0018);
    debug_reset_in = 1'b1;
    @(posedge clk);
    #1 debug_reset_in = 1'b0;
    rd(2'h1);
    chk({v, ise_disp}, {16'h0000, 2'b10});
    report_and_stop;
  end
endmodule : breakpoint_channel_control_bench
